// ---- dsp_pkg.sv ----
// Shared constants for the dual serial port block: register map, field
// layout, reset values, codes and timing. Assumes a 125 MHz core clock.
`default_nettype none

package dsp_pkg;

  // ---------------------------------------------------------------
  // Bus and structure
  // ---------------------------------------------------------------
  localparam int NPORT = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EV_PER_PORT = 4;

  // ---------------------------------------------------------------
  // Register offsets (port n at base (n-1)*0x20)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_CFG = 5'h00;
  localparam logic [4:0] OFF_DIV = 5'h04;
  localparam logic [4:0] OFF_DIR = 5'h08;
  localparam logic [4:0] OFF_TXD = 5'h0C;
  localparam logic [4:0] OFF_RXD = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;
  localparam logic [2:0] GLOBAL_PAGE = 3'h2;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h00;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;

  // ---------------------------------------------------------------
  // Configuration fields and codes
  // ---------------------------------------------------------------
  localparam int CFG_W = 7;
  localparam int CFG_PAR_LSB = 0;
  localparam int CFG_LEN_LSB = 2;
  localparam int CFG_STOP_BIT = 4;
  localparam int CFG_PROTO_LSB = 5;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PROTO_PLAIN = 2'h0;
  localparam logic [1:0] PROTO_RTSCTS = 2'h1;
  localparam logic [1:0] PROTO_XONXOFF = 2'h2;
  localparam logic [1:0] PROTO_RS485 = 2'h3;
  localparam logic [1:0] DIR_RECV = 2'h0;
  localparam logic [1:0] DIR_SEND = 2'h1;
  localparam logic [1:0] DIR_ECHO = 2'h2;
  localparam logic [1:0] DIR_MUTE = 2'h3;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;

  // Status bits, event bits
  localparam int ST_TXBUSY = 0;
  localparam int ST_RXEMPTY = 1;
  localparam int ST_TXFULL = 2;
  localparam int ST_WRFAIL = 3;
  localparam int EV_RX = 0;
  localparam int EV_TXDONE = 1;
  localparam int EV_LINEERR = 2;
  localparam int EV_OVERRUN = 3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_MIN = 35;
  localparam int BAUD_MAX_RS232 = 115_200;
  localparam int BAUD_MAX_RS485 = 2_304_000;
  localparam int BAUD_RESET = 9_600;
  localparam int DIV_W = 18;
  localparam logic [DIV_W-1:0] DIV_MIN_RS232 = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_MAX_RS232));
  localparam logic [DIV_W-1:0] DIV_MIN_RS485 = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_MAX_RS485));
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_MIN));
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_RESET));
  localparam logic [5:0] TICK_LAST = 6'h0F;
  localparam logic [5:0] TICK_MID = 6'h07;
  localparam logic [5:0] STOP_T1 = 6'h10;
  localparam logic [5:0] STOP_T15 = 6'h18;
  localparam logic [5:0] STOP_T2 = 6'h20;

  // Reset values: no parity, 8 bits, 1 stop, RS485, receive
  localparam logic [CFG_W-1:0] CFG_RESET = {PROTO_RS485, 1'b0, 2'h3, PAR_NONE};
  localparam logic [1:0] DIR_RESET = DIR_RECV;
  localparam logic [DATA_W-1:0] RX_EMPTY_VAL = 32'hFFFFFFFF;

  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_LOAD = 6'h02, TX_START = 6'h04,
    TX_DATA = 6'h08, TX_PAR = 6'h10, TX_STOP = 6'h20
  } dsp_tx_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PAR = 5'h08, RX_STOP = 5'h10
  } dsp_rx_e;

endpackage

`default_nettype wire

// ---- dsp_fifo_if.sv ----
// Handshake bundle between the serial port core and its queue memories.
// Assumes a single clock shared by both ends.
`default_nettype none

interface dsp_fifo_if #(parameter int W = 8);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic clr;
  logic full;
  logic empty;
  logic [W-1:0] rdata;
  modport store (input push, wdata, pop, clr, output full, empty, rdata);
  modport user (output push, wdata, pop, clr, input full, empty, rdata);
endinterface

`default_nettype wire

// ---- dsp_fifo.sv ----
// Small queue memory with a registered read port.
// Read data appear in the cycle after a pop; push and pop may coincide.
`default_nettype none

module dsp_fifo
  import dsp_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  dsp_fifo_if.store f
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic [W-1:0] rdata_reg;
  logic do_push;
  logic do_pop;

  assign f.empty = (wptr_reg == rptr_reg);
  assign f.full = (wptr_reg == {~rptr_reg[AW], rptr_reg[AW-1:0]});
  assign f.rdata = rdata_reg;
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wptr_reg[AW-1:0]] <= f.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      rdata_reg <= '0;
    end else if (f.clr) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rdata_reg <= mem[rptr_reg[AW-1:0]];
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

endmodule // dsp_fifo

`default_nettype wire

// ---- dsp_serial.sv ----
// Dual serial port controller with register port, queues and interrupt.
// Assumes pins synchronous to core_clk and an external line transceiver.
//
// Summary of operation
// - Busy status low only when queue, shifter empty
// - Empty receive queue reads as minus one
// - Direction 0 in RS485: receive only, never transmit
// - Direction 1: send queued data onto bus
// - Direction 2 in RS485: send and receive own characters
// - Direction 3 in RS485: receiver runs, characters discarded
// - Parity none, even or odd, both ways
// - Character length five to eight bits
// - Stop code 1: 1.5 or 2 stops
// - Four protocols, RS485 by default
// - Baud range limited per protocol
// - Two independent ports, each with own settings
// - Registers readable and writable by address
// - Send queue write refused when full
// - Controller reset clears all port settings
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`default_nettype none

module dsp_serial
  import dsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic [NPORT-1:0] rxd,
  output logic [NPORT-1:0] txd,
  output logic [NPORT-1:0] de,
  output logic [NPORT-1:0] rts_n,
  input wire logic [NPORT-1:0] cts_n
);

  localparam int NEV = NPORT * EV_PER_PORT;

  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  logic [4:0] off;
  logic glob_hit;
  logic soft_rst;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] irq_stat_reg;
  logic [NEV-1:0] irq_mask_reg;
  logic [DATA_W-1:0] port_rd [NPORT];
  logic [7:0] rx_head [NPORT];
  logic [NPORT-1:0] rx_empty_w;
  logic [DATA_W-1:0] rdata_reg;
  logic rxsel_reg;
  logic rxempty_reg;
  logic [0:0] rxport_reg;

  assign off = reg_addr[4:0];
  assign glob_hit = (reg_addr[7:5] == GLOBAL_PAGE);
  assign soft_rst = reg_wr && glob_hit && (off == OFF_CTRL) && reg_wdata[0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else if (reg_wr && glob_hit && (off == OFF_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~reg_wdata[NEV-1:0]) | ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (reg_wr && glob_hit && (off == OFF_IRQ_MASK)) begin
      irq_mask_reg <= reg_wdata[NEV-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      rxsel_reg <= 1'b0;
      rxempty_reg <= 1'b0;
      rxport_reg <= '0;
    end else begin
      rxsel_reg <= 1'b0;
      if (reg_rd) begin
        rdata_reg <= '0;
        if (glob_hit && off == OFF_IRQ_STAT) begin
          rdata_reg <= DATA_W'(irq_stat_reg);
        end else if (glob_hit && off == OFF_IRQ_MASK) begin
          rdata_reg <= DATA_W'(irq_mask_reg);
        end else if (reg_addr[7:5] < 3'(NPORT)) begin
          rdata_reg <= port_rd[reg_addr[5]];
          if (off == OFF_RXD) begin
            rxsel_reg <= 1'b1;
            rxport_reg <= reg_addr[5];
            rxempty_reg <= rx_empty_w[reg_addr[5]];
          end
        end
      end
    end
  end

  always_comb begin
    reg_rdata = rdata_reg;
    if (rxsel_reg) begin
      reg_rdata = rxempty_reg ? RX_EMPTY_VAL : {24'h000000, rx_head[rxport_reg]};
    end
  end

  // ---------------------------------------------------------------
  // Per-port logic
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic hit;
    logic [CFG_W-1:0] cfg_reg;
    logic [DIV_W-1:0] div_reg;
    logic [1:0] dir_reg;
    logic wrfail_reg;
    logic [1:0] par;
    logic [1:0] len;
    logic [1:0] proto;
    logic [DIV_W-1:0] div_eff;
    logic [DIV_W-1:0] div_lo;
    logic [DIV_W-1:0] bcnt_reg;
    logic tick;
    logic [7:0] mask;
    logic [2:0] last_bit;
    logic [5:0] stop_t;
    logic tx_go;
    logic rx_store;
    logic rx_in;
    logic xoff_reg;
    logic busy;
    logic busy_reg;
    dsp_tx_e tx_st;
    logic [5:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic txd_reg;
    dsp_rx_e rx_st;
    logic [5:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_bad;
    logic rx_done;
    logic rx_flow;

    dsp_fifo_if #(.W(8)) txq ();
    dsp_fifo_if #(.W(8)) rxq ();

    dsp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txq (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .f(txq)
    );
    dsp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rxq (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .f(rxq)
    );

    assign hit = (reg_addr[7:5] == 3'(p));
    assign par = cfg_reg[CFG_PAR_LSB +: 2];
    assign len = cfg_reg[CFG_LEN_LSB +: 2];
    assign proto = cfg_reg[CFG_PROTO_LSB +: 2];

    // Settings, cleared by power-on reset and by controller reset
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_reg <= CFG_RESET;
        div_reg <= DIV_RESET;
        dir_reg <= DIR_RESET;
      end else if (soft_rst) begin
        cfg_reg <= CFG_RESET;
        div_reg <= DIV_RESET;
        dir_reg <= DIR_RESET;
      end else if (reg_wr && hit) begin
        if (off == OFF_CFG) begin
          cfg_reg <= reg_wdata[CFG_W-1:0];
        end
        if (off == OFF_DIV) begin
          div_reg <= reg_wdata[DIV_W-1:0];
        end
        if (off == OFF_DIR) begin
          dir_reg <= reg_wdata[1:0];
        end
      end
    end

    // Baud tick at 16x the bit rate, divisor held inside the legal band
    assign div_lo = (proto == PROTO_RS485) ? DIV_MIN_RS485 : DIV_MIN_RS232;
    assign div_eff = (div_reg < div_lo) ? div_lo : ((div_reg > DIV_MAX) ? DIV_MAX : div_reg);
    assign tick = (bcnt_reg >= div_eff - 1'b1);

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        bcnt_reg <= '0;
      end else begin
        bcnt_reg <= tick ? '0 : bcnt_reg + 1'b1;
      end
    end

    // Frame shape
    assign mask = 8'hFF >> (2'h3 - len);
    assign last_bit = 3'(len) + 3'h4;
    assign stop_t = !cfg_reg[CFG_STOP_BIT] ? STOP_T1 : ((len == 2'h0) ? STOP_T15 : STOP_T2);

    // Send queue write with refusal when full
    assign txq.push = reg_wr && hit && (off == OFF_TXD);
    assign txq.wdata = reg_wdata[7:0];
    assign txq.clr = soft_rst;
    assign rxq.clr = soft_rst;

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        wrfail_reg <= 1'b0;
      end else if (soft_rst) begin
        wrfail_reg <= 1'b0;
      end else if (txq.push) begin
        wrfail_reg <= txq.full;
      end
    end

    // Transmit permission: direction for RS485, flow control for RS232
    always_comb begin
      tx_go = 1'b1;
      unique case (proto)
        PROTO_RS485: tx_go = (dir_reg == DIR_SEND) || (dir_reg == DIR_ECHO);
        PROTO_RTSCTS: tx_go = !cts_n[p];
        PROTO_XONXOFF: tx_go = !xoff_reg;
        PROTO_PLAIN: tx_go = 1'b1;
      endcase
    end

    assign txq.pop = (tx_st == TX_IDLE) && tx_go && !txq.empty;

    // Transmitter
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        tx_st <= TX_IDLE;
        tx_sub <= '0;
        tx_bit <= '0;
        tx_sh <= '0;
        tx_par <= 1'b0;
        txd_reg <= 1'b1;
      end else if (soft_rst) begin
        tx_st <= TX_IDLE;
        txd_reg <= 1'b1;
      end else begin
        unique case (tx_st)
          TX_IDLE: begin
            txd_reg <= 1'b1;
            if (txq.pop) begin
              tx_st <= TX_LOAD;
            end
          end
          TX_LOAD: begin
            tx_sh <= txq.rdata & mask;
            tx_par <= (^(txq.rdata & mask)) ^ (par == PAR_ODD);
            tx_sub <= '0;
            txd_reg <= 1'b0;
            tx_st <= TX_START;
          end
          TX_START: if (tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == TICK_LAST) begin
              tx_sub <= '0;
              tx_bit <= '0;
              txd_reg <= tx_sh[0];
              tx_st <= TX_DATA;
            end
          end
          TX_DATA: if (tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == TICK_LAST) begin
              tx_sub <= '0;
              tx_bit <= tx_bit + 1'b1;
              tx_sh <= tx_sh >> 1;
              txd_reg <= tx_sh[1];
              if (tx_bit == last_bit) begin
                txd_reg <= (par == PAR_NONE) ? 1'b1 : tx_par;
                tx_st <= (par == PAR_NONE) ? TX_STOP : TX_PAR;
              end
            end
          end
          TX_PAR: if (tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == TICK_LAST) begin
              tx_sub <= '0;
              txd_reg <= 1'b1;
              tx_st <= TX_STOP;
            end
          end
          TX_STOP: if (tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == stop_t - 1'b1) begin
              tx_st <= TX_IDLE;
            end
          end
        endcase
      end
    end

    assign txd[p] = txd_reg;
    assign de[p] = (proto == PROTO_RS485) && !(tx_st inside {TX_IDLE, TX_LOAD});
    assign busy = !txq.empty || (tx_st != TX_IDLE);

    // Receiver input: in echo mode the own frame is looped back
    assign rx_in = ((proto == PROTO_RS485) && (dir_reg == DIR_ECHO) && (tx_st != TX_IDLE))
                   ? txd_reg : rxd[p];
    assign rx_store = (proto != PROTO_RS485) || (dir_reg == DIR_RECV) || (dir_reg == DIR_ECHO);
    assign rx_flow = (proto == PROTO_XONXOFF) && ((rx_sh == CHAR_XON) || (rx_sh == CHAR_XOFF));
    assign rx_done = (rx_st == RX_STOP) && tick && (rx_sub == TICK_LAST) && rx_in && !rx_bad;
    assign rxq.push = rx_done && rx_store && !rx_flow;
    assign rxq.wdata = rx_sh;
    assign rxq.pop = reg_rd && hit && (off == OFF_RXD);

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        rx_st <= RX_IDLE;
        rx_sub <= '0;
        rx_bit <= '0;
        rx_sh <= '0;
        rx_bad <= 1'b0;
      end else if (soft_rst) begin
        rx_st <= RX_IDLE;
      end else begin
        unique case (rx_st)
          RX_IDLE: if (!rx_in) begin
            rx_sub <= '0;
            rx_sh <= '0;
            rx_bad <= 1'b0;
            rx_st <= RX_START;
          end
          RX_START: if (tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == TICK_MID) begin
              rx_sub <= '0;
              rx_bit <= '0;
              rx_st <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: if (tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == TICK_LAST) begin
              rx_sub <= '0;
              rx_sh[rx_bit] <= rx_in;
              rx_bit <= rx_bit + 1'b1;
              if (rx_bit == last_bit) begin
                rx_st <= (par == PAR_NONE) ? RX_STOP : RX_PAR;
              end
            end
          end
          RX_PAR: if (tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == TICK_LAST) begin
              rx_sub <= '0;
              rx_bad <= rx_in != ((^rx_sh) ^ (par == PAR_ODD));
              rx_st <= RX_STOP;
            end
          end
          RX_STOP: if (tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == TICK_LAST) begin
              rx_st <= RX_IDLE;
            end
          end
        endcase
      end
    end

    // Software flow control state and own ready signal
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        xoff_reg <= 1'b0;
      end else if (soft_rst || proto != PROTO_XONXOFF) begin
        xoff_reg <= 1'b0;
      end else if (rx_done) begin
        if (rx_sh == CHAR_XOFF) begin
          xoff_reg <= 1'b1;
        end else if (rx_sh == CHAR_XON) begin
          xoff_reg <= 1'b0;
        end
      end
    end

    assign rts_n[p] = (proto == PROTO_RTSCTS) && rxq.full;

    // Events
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        busy_reg <= 1'b0;
      end else begin
        busy_reg <= busy;
      end
    end

    assign ev[p*EV_PER_PORT + EV_RX] = rxq.push && !rxq.full;
    assign ev[p*EV_PER_PORT + EV_TXDONE] = busy_reg && !busy;
    assign ev[p*EV_PER_PORT + EV_LINEERR] = (rx_st == RX_STOP) && tick
                                            && (rx_sub == TICK_LAST) && (rx_bad || !rx_in);
    assign ev[p*EV_PER_PORT + EV_OVERRUN] = rxq.push && rxq.full;

    // Register view of this port
    always_comb begin
      port_rd[p] = '0;
      if (off == OFF_CFG) begin
        port_rd[p] = DATA_W'(cfg_reg);
      end else if (off == OFF_DIV) begin
        port_rd[p] = DATA_W'(div_reg);
      end else if (off == OFF_DIR) begin
        port_rd[p] = DATA_W'(dir_reg);
      end else if (off == OFF_STAT) begin
        port_rd[p] = DATA_W'({wrfail_reg, txq.full, rxq.empty, busy});
      end
    end

    assign rx_head[p] = rxq.rdata;
    assign rx_empty_w[p] = rxq.empty;
  end

endmodule // dsp_serial

`default_nettype wire

// ---- dsp_serial_props.sv ----
// Checker for the dual serial port top: bus, line and interrupt relations.
// Assumes one core_clk domain; bound to every dsp_serial instance.
`default_nettype none

module dsp_serial_props
  import dsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic [NPORT-1:0] rxd,
  input wire logic [NPORT-1:0] txd,
  input wire logic [NPORT-1:0] de,
  input wire logic [NPORT-1:0] rts_n,
  input wire logic [NPORT-1:0] cts_n
);
  logic [1:0] proto_reg;
  logic [1:0] dir_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Port 1 protocol and direction as software last set them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      proto_reg <= PROTO_RS485;
      dir_reg <= DIR_RESET;
    end else if (reg_wr && reg_addr == 8'h48 && reg_wdata[0]) begin
      proto_reg <= PROTO_RS485;
      dir_reg <= DIR_RESET;
    end else if (reg_wr && reg_addr == 8'h00) begin
      proto_reg <= reg_wdata[6:5];
    end else if (reg_wr && reg_addr == 8'h08) begin
      dir_reg <= reg_wdata[1:0];
    end
  end

  property p_quiet;
    proto_reg == PROTO_RS485 && dir_reg == DIR_RECV |-> txd[0] && !de[0];
  endproperty
  a_quiet: assert property (p_quiet) else $error("port sends in receive mode");
  property p_de_start;
    $rose(de[0]) |-> !txd[0];
  endproperty
  a_de_start: assert property (p_de_start) else $error("driver on without start");
  property p_start_len;
    $fell(txd[0]) |-> !txd[0] [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  property p_unmapped;
    reg_rd && reg_addr == 8'h3C |=> reg_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_busy;
    reg_rd && reg_addr == 8'h14 && de[0] |=> reg_rdata[ST_TXBUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("idle shown while sending");
  property p_soft;
    reg_wr && reg_addr == 8'h48 && reg_wdata[0] |=> de == 2'b00;
  endproperty
  a_soft: assert property (p_soft) else $error("driver on after reset");
  property p_mask;
    reg_wr && reg_addr == 8'h44 && reg_wdata == 32'h0 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt with all masked");
  property p_rts;
    proto_reg != PROTO_RTSCTS |-> !rts_n[0];
  endproperty
  a_rts: assert property (p_rts) else $error("ready raised outside handshake");

  c_send: cover property ($rose(de[0]));
  c_rx: cover property (reg_rd && reg_addr == 8'h10 ##1 reg_rdata != RX_EMPTY_VAL);
  c_irq: cover property ($rose(irq));
endmodule // dsp_serial_props

bind dsp_serial dsp_serial_props i_dsp_serial_props (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .rxd(rxd), .txd(txd), .de(de), .rts_n(rts_n),
  .cts_n(cts_n));

`default_nettype wire

// ---- dsp_station.sv ----
// Remote serial station on the port 1 line: sends frames, collects 8N1 frames.
// Assumes BITC core_clk cycles per bit; line idles high.
`default_nettype none

module dsp_station
  import dsp_pkg::*;
#(
  parameter int BITC = 48
) (
  input wire logic core_clk,
  input wire logic line_in,
  output logic line_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];

  task automatic send_char(input logic [7:0] d, input int nb, input logic [1:0] par,
    input int stops, input logic bad);
    logic [7:0] m;
    logic p;
    m = d & (8'hFF >> (8 - nb));
    p = (^m) ^ (par == PAR_ODD) ^ bad;
    @(posedge core_clk);
    line_out <= 1'b0;
    repeat (BITC) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= m[i];
      repeat (BITC) @(posedge core_clk);
    end
    if (par != PAR_NONE) begin
      line_out <= p;
      repeat (BITC) @(posedge core_clk);
    end
    line_out <= 1'b1;
    repeat (BITC * stops) @(posedge core_clk);
  endtask

  initial begin
    logic [7:0] c;
    forever begin
      @(negedge line_in);
      repeat (BITC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BITC) @(posedge core_clk);
        c[i] = line_in;
      end
      repeat (BITC) @(posedge core_clk);
      rx_q.push_back(c);
    end
  end
endmodule // dsp_station

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the dual serial port: register port and line.
// Assumes the station model on port 1; port 2 line held idle.
`default_nettype none

module tb_top
  import dsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic irq;
  logic line1;
  logic [NPORT-1:0] txd;
  logic [NPORT-1:0] de;
  logic [NPORT-1:0] rts_n;
  logic [DATA_W-1:0] v;
  logic [6:0] cfg;
  logic [7:0] mk;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] sent [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h81};
  always #4 core_clk = ~core_clk;
  dsp_serial #(.FIFO_DEPTH(4)) i_dsp_serial (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .rxd({1'b1, line1}), .txd(txd), .de(de),
    .rts_n(rts_n), .cts_n(2'b00));
  dsp_station #(.BITC(48)) i_dsp_station (.core_clk(core_clk), .line_in(txd[0]),
    .line_out(line1));

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(n, e, v);
  endtask
  task automatic drain();
    rd(8'h14);
    for (int k = 0; k < 2000 && v[ST_TXBUSY] !== 1'b0; k++) rd(8'h14);
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    chk("cfg1", 8'h00, 32'h0000006C);
    chk("div1", 8'h04, 32'h0000032D);
    chk("stat1", 8'h14, 32'h00000002);
    chk("rx1", 8'h10, RX_EMPTY_VAL);
    chk("unmapped", 8'h3C, 32'h00000000);
    wr(8'h04, 32'h00000003);
    chk("div1", 8'h04, 32'h00000003);
    wr(8'h08, 32'h00000000);
    wr(8'h0C, 32'h000000A5);
    repeat (200) @(posedge core_clk);
    chk("stat1", 8'h14, 32'h00000003);
    wr(8'h0C, 32'h0000005A);
    wr(8'h0C, 32'h000000C3);
    wr(8'h0C, 32'h00000081);
    chk("stat1", 8'h14, 32'h00000007);
    wr(8'h0C, 32'h0000007E);
    chk("stat1", 8'h14, 32'h0000000F);
    wr(8'h44, 32'h00000002);
    wr(8'h08, 32'h00000001);
    drain();
    cmp("busy", 32'h0, {31'h0, v[ST_TXBUSY]});
    cmp("frames", 32'h4, i_dsp_station.rx_q.size());
    foreach (sent[i]) cmp("char", 32'(sent[i]), 32'(i_dsp_station.rx_q[i]));
    cmp("c0", 32'hA5, i_dsp_station.rx_q[0]);
    cmp("c3", 32'h81, i_dsp_station.rx_q[3]);
    cmp("irq", 32'h1, 32'(irq));
    wr(8'h40, 32'h00000002);
    cmp("irq", 32'h0, 32'(irq));
    wr(8'h44, 32'h00000000);
    wr(8'h08, 32'h00000002);
    wr(8'h0C, 32'h0000003C);
    drain();
    repeat (100) @(posedge core_clk);
    chk("echo", 8'h10, 32'h0000003C);
    chk("rx1", 8'h10, RX_EMPTY_VAL);
    wr(8'h08, 32'h00000003);
    i_dsp_station.send_char(8'h12, 8, PAR_NONE, 1, 1'b0);
    repeat (100) @(posedge core_clk);
    chk("mute", 8'h10, RX_EMPTY_VAL);
    wr(8'h08, 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      cfg = {PROTO_RS485, k[0], k[1:0], 2'(k % 3)};
      mk = 8'hFF >> (3 - k);
      wr(8'h00, {25'h0, cfg});
      i_dsp_station.send_char(8'hA5 ^ 8'(k), 5 + k, cfg[1:0], 1 + k[0], 1'b0);
      i_dsp_station.send_char(8'h5A + 8'(k), 5 + k, cfg[1:0], 1 + k[0], 1'b0);
      repeat (100) @(posedge core_clk);
      chk("first", 8'h10, {24'h0, (8'hA5 ^ 8'(k)) & mk});
      chk("second", 8'h10, {24'h0, (8'h5A + 8'(k)) & mk});
    end
    wr(8'h00, 32'h0000006D);
    i_dsp_station.send_char(8'h33, 8, PAR_EVEN, 1, 1'b1);
    repeat (100) @(posedge core_clk);
    chk("badpar", 8'h10, RX_EMPTY_VAL);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, {25'h0, 2'(p), 5'h0D});
      chk("proto", 8'h00, {25'h0, 2'(p), 5'h0D});
    end
    chk("cfg2", 8'h20, 32'h0000006C);
    chk("div2", 8'h24, 32'h0000032D);
    wr(8'h08, 32'h00000003);
    wr(8'h48, 32'h00000001);
    chk("cfg1", 8'h00, 32'h0000006C);
    chk("div1", 8'h04, 32'h0000032D);
    chk("dir1", 8'h08, 32'h00000000);
    final_report();
  end
endmodule // tb_top

`default_nettype wire
